// ==== rtl/wocr_consts.svh ====
// Offsets, bit positions, reset values and timing counts of the option registers.
`ifndef WOCR_CONSTS_SVH
`define WOCR_CONSTS_SVH
`define WOCR_OFS_TWO         8'h1e
`define WOCR_OFS_ONE         8'h1f
`define WOCR_ONE_PERIOD      7
`define WOCR_ONE_MON_HALT    6
`define WOCR_ONE_UV_RST_DIS  5
`define WOCR_ONE_UV_PWR_DIS  4
`define WOCR_ONE_UV_RANGE    3
`define WOCR_ONE_SHORT_REC   2
`define WOCR_ONE_HALT_EN     1
`define WOCR_ONE_WD_DIS      0
`define WOCR_TWO_PULL_DIS    7
`define WOCR_TWO_INT_EN      6
`define WOCR_TWO_OSC_HI      4
`define WOCR_TWO_OSC_LO      3
`define WOCR_TWO_RST_PIN     0
`define WOCR_RESET_VAL       8'h00
`define WOCR_WD_SHORT        19'd8176
`define WOCR_WD_LONG         19'd262128
`define WOCR_WAKE_SHORT      15'd512
`define WOCR_WAKE_LONG       15'd16384
`define WOCR_REC_SHORT       13'd32
`define WOCR_REC_LONG        13'd4096
`endif

// ==== rtl/wocr_pkg.sv ====
// Types shared by the option register bank.
package wocr_pkg;
    typedef enum logic [1:0] {
        WOCR_OSC_INTERNAL = 2'b00,
        WOCR_OSC_EXTERNAL = 2'b01,
        WOCR_OSC_EXT_RC   = 2'b10,
        WOCR_OSC_CRYSTAL  = 2'b11
    } wocr_osc_t;
    typedef struct packed {
        logic [7:0]  reg_two;
        logic [7:0]  reg_one;
        logic        done_two;
        logic        done_one;
        logic [7:0]  rd_data;
        logic [18:0] wd_period;
        logic [14:0] wake_period;
        logic [12:0] rec_delay;
        logic        uv_powered;
        logic        uv_in_halt;
        logic        uv_rst_out;
        logic        uv_range_hi;
        logic        halt_allowed;
        logic        wd_enable;
        logic        pull_connect;
        logic        int_pin_on;
        wocr_osc_t   osc_src;
        logic        rst_pin_on;
        logic [1:0]  por_sync;
        logic [1:0]  uvreq_sync;
    } wocr_state_t;
endpackage

// ==== rtl/wocr_bank.sv ====
// Write-once option register bank with decoded option outputs.
// Functional notes
// - One write per register after reset, always readable.
// - Two registers decode at 0x1e and 0x1f.
// - Range bit cleared only by power-on reset.
// - Reset pin bit cleared only by power-on.
// - Watchdog timeout 8176 or 262128 oscillator cycles.
// - In halt, wakeup period 512 or 16384.
// - Monitor stays on in halt when bit set and power disable clear.
// - Reset disable suppresses monitor reset requests.
// - Power disable switches the monitor off.
// - Range bit selects 5 V or 3 V trip.
// - Halt recovery 32 or 4096 oscillator cycles.
// - Monitor-reset halt exit uses long recovery.
// - Halt instruction illegal unless enable set.
// - Watchdog disable bit turns watchdog off.
// - Pullup disconnected when bit set.
// - External interrupt function on when set.
// - Oscillator source field selects four sources.
`timescale 1ns/1ps
`include "wocr_consts.svh"
module wocr_bank (
    // Clock and reset.
    input  wire logic              clock,
    input  wire logic              sys_rst,
    // Power-on reset level from the supply monitor, asynchronous.
    input  wire logic              por_in,
    // Register port.
    input  wire logic [7:0]        addr,
    input  wire logic [7:0]        wr_data,
    input  wire logic              wr_stb,
    input  wire logic              rd_stb,
    output logic      [7:0]        rd_data,
    // Context from the rest of the device.
    input  wire logic              in_halt,
    input  wire logic              uv_reset_req,
    input  wire logic              halt_exit_by_uv,
    // Decoded options.
    output logic      [18:0]       wd_period,
    output logic      [14:0]       wake_period,
    output logic      [12:0]       rec_delay,
    output logic                   uv_powered,
    output logic                   uv_in_halt,
    output logic                   uv_rst_out,
    output logic                   uv_range_hi,
    output logic                   halt_allowed,
    output logic                   wd_enable,
    output logic                   pull_connect,
    output logic                   int_pin_on,
    output wocr_pkg::wocr_osc_t    osc_src,
    output logic                   rst_pin_on
);
    import wocr_pkg::*;

    wocr_state_t state;
    wocr_state_t next_state;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    // Bits that survive an ordinary reset but not a power-on reset.
    localparam logic [7:0] KEEP_ONE = 8'h08;
    localparam logic [7:0] KEEP_TWO = 8'h01;

    always_comb begin
        next_state = state;
        next_state.por_sync = {state.por_sync[0], por_in};
        next_state.uvreq_sync = {state.uvreq_sync[0], uv_reset_req};
        // A write lands only while the register is still unwritten.
        if (wr_stb && hit(addr, `WOCR_OFS_TWO) && !state.done_two) begin
            next_state.reg_two = wr_data;
            next_state.done_two = 1'b1;
        end
        if (wr_stb && hit(addr, `WOCR_OFS_ONE) && !state.done_one) begin
            next_state.reg_one = wr_data;
            next_state.done_one = 1'b1;
        end
        // Read data shows the stored value; unmapped reads return zero.
        next_state.rd_data = 8'h00;
        if (rd_stb && hit(addr, `WOCR_OFS_TWO)) begin
            next_state.rd_data = state.reg_two;
        end else if (rd_stb && hit(addr, `WOCR_OFS_ONE)) begin
            next_state.rd_data = state.reg_one;
        end
        // Decoding from the stored bits; one cycle of latency keeps outputs
        // straight from flip-flops.
        next_state.wd_period = state.reg_one[`WOCR_ONE_PERIOD] ?
            `WOCR_WD_SHORT : `WOCR_WD_LONG;
        next_state.wake_period = state.reg_one[`WOCR_ONE_PERIOD] ?
            `WOCR_WAKE_SHORT : `WOCR_WAKE_LONG;
        // A monitor-caused halt exit always takes the long delay.
        next_state.rec_delay = (state.reg_one[`WOCR_ONE_SHORT_REC] &&
            !halt_exit_by_uv) ? `WOCR_REC_SHORT : `WOCR_REC_LONG;
        next_state.uv_powered = !state.reg_one[`WOCR_ONE_UV_PWR_DIS];
        next_state.uv_in_halt = !state.reg_one[`WOCR_ONE_UV_PWR_DIS] &&
            state.reg_one[`WOCR_ONE_MON_HALT];
        next_state.uv_rst_out = state.uvreq_sync[1] &&
            !state.reg_one[`WOCR_ONE_UV_RST_DIS];
        next_state.uv_range_hi = state.reg_one[`WOCR_ONE_UV_RANGE];
        next_state.halt_allowed = state.reg_one[`WOCR_ONE_HALT_EN];
        next_state.wd_enable = !state.reg_one[`WOCR_ONE_WD_DIS];
        next_state.pull_connect = !state.reg_two[`WOCR_TWO_PULL_DIS];
        next_state.int_pin_on = state.reg_two[`WOCR_TWO_INT_EN];
        next_state.osc_src = wocr_osc_t'({state.reg_two[`WOCR_TWO_OSC_HI],
            state.reg_two[`WOCR_TWO_OSC_LO]});
        next_state.rst_pin_on = state.reg_two[`WOCR_TWO_RST_PIN];
        // The wakeup period is only meaningful while halted.
        if (!in_halt) begin
            next_state.wake_period = state.wake_period;
        end
        // Ordinary reset clears all but the kept bits; power-on clears all.
        if (sys_rst || state.por_sync[1]) begin
            next_state.done_two = 1'b0;
            next_state.done_one = 1'b0;
            next_state.rd_data = 8'h00;
            // Without this the held wakeup period stays unknown until halt.
            next_state.wake_period = 15'h0000;
            next_state.uvreq_sync = 2'b00;
            if (state.por_sync[1]) begin
                next_state.reg_one = `WOCR_RESET_VAL;
                next_state.reg_two = `WOCR_RESET_VAL;
            end else begin
                next_state.reg_one = state.reg_one & KEEP_ONE;
                next_state.reg_two = state.reg_two & KEEP_TWO;
            end
        end
    end

    // Synchronous reset cannot clear everything: kept bits need their value.
    always_ff @(posedge clock) begin
        state <= next_state;
    end

    assign rd_data      = state.rd_data;
    assign wd_period    = state.wd_period;
    assign wake_period  = state.wake_period;
    assign rec_delay    = state.rec_delay;
    assign uv_powered   = state.uv_powered;
    assign uv_in_halt   = state.uv_in_halt;
    assign uv_rst_out   = state.uv_rst_out;
    assign uv_range_hi  = state.uv_range_hi;
    assign halt_allowed = state.halt_allowed;
    assign wd_enable    = state.wd_enable;
    assign pull_connect = state.pull_connect;
    assign int_pin_on   = state.int_pin_on;
    assign osc_src      = state.osc_src;
    assign rst_pin_on   = state.rst_pin_on;

    write_once_a: assert property (@(posedge clock) disable iff (sys_rst)
        state.done_one && !state.por_sync[1] |=> $stable(state.reg_one))
        else $error("option one changed after its write");
    first_write_a: assert property (@(posedge clock) disable iff (sys_rst)
        wr_stb && addr == 8'h1e && !state.done_two && !state.por_sync[1]
        |=> state.reg_two == $past(wr_data))
        else $error("option two first write lost");
    read_back_a: assert property (@(posedge clock) disable iff (sys_rst)
        rd_stb && addr == 8'h1f && !state.por_sync[1]
        |=> rd_data == $past(state.reg_one))
        else $error("option one read wrong");
    keep_range_a: assert property (@(posedge clock)
        sys_rst && !state.por_sync[1]
        |=> state.reg_one[3] == $past(state.reg_one[3]))
        else $error("range bit lost on reset");
    keep_pin_a: assert property (@(posedge clock)
        sys_rst && !state.por_sync[1]
        |=> state.reg_two[0] == $past(state.reg_two[0]))
        else $error("reset pin bit lost on reset");
    wd_period_a: assert property (@(posedge clock) disable iff (sys_rst)
        state.reg_one[7] |=> wd_period == 19'd8176)
        else $error("watchdog short period wrong");
    long_rec_a: assert property (@(posedge clock) disable iff (sys_rst)
        halt_exit_by_uv |=> rec_delay == 13'd4096)
        else $error("monitor reset exit not long");
    uv_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
        state.reg_one[5] |=> !uv_rst_out)
        else $error("monitor reset not suppressed");
endmodule

// ==== testbench/write_once_config_registers_test.sv ====
// Self-checking bench for the write-once option register bank.
`timescale 1ns/1ps
`include "wocr_consts.svh"
module write_once_config_registers_test;
    import wocr_pkg::*;
    logic        clock = 0, sys_rst = 1, por_in = 1;
    logic [7:0]  addr = 8'h00, wr_data = 8'h00, rd_data;
    logic        wr_stb = 0, rd_stb = 0, in_halt = 0;
    logic        uv_reset_req = 0, halt_exit_by_uv = 0, rd_pend = 0;
    logic [18:0] wd_period;
    logic [14:0] wake_period;
    logic [12:0] rec_delay;
    logic        uv_powered, uv_in_halt, uv_rst_out, uv_range_hi;
    logic        halt_allowed, wd_enable, pull_connect, int_pin_on;
    logic        rst_pin_on;
    wocr_osc_t   osc_src;
    logic [7:0]  m1 = 8'h00, m2 = 8'h00, v1, v2;
    logic [7:0]  exp_q[$];
    integer      seed = 32'hd22c9b90, err_total = 0, tests_run = 0;
    integer      cycles = 0;

    wocr_bank i_dut (.clock(clock), .sys_rst(sys_rst), .por_in(por_in),
        .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rd_data(rd_data), .in_halt(in_halt), .uv_reset_req(uv_reset_req),
        .halt_exit_by_uv(halt_exit_by_uv), .wd_period(wd_period),
        .wake_period(wake_period), .rec_delay(rec_delay),
        .uv_powered(uv_powered), .uv_in_halt(uv_in_halt),
        .uv_rst_out(uv_rst_out), .uv_range_hi(uv_range_hi),
        .halt_allowed(halt_allowed), .wd_enable(wd_enable),
        .pull_connect(pull_connect), .int_pin_on(int_pin_on),
        .osc_src(osc_src), .rst_pin_on(rst_pin_on));

    initial forever #5 clock = ~clock;

    task final_report;
        $display("mismatches %0d of %0d checks", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk(input string nm, input logic [18:0] e, input logic [18:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Read data stand only in the cycle after the strobe, so compare there.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            err_total++;
            final_report;
        end
        if (rd_pend)
            chk("rd_data", exp_q.size() ? exp_q.pop_front() : 19'h7ffff,
                rd_data);
        rd_pend <= rd_stb;
    end

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a; wr_data <= d; wr_stb <= 1; rd_stb <= 0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        addr <= a; rd_stb <= 1; wr_stb <= 0;
        exp_q.push_back(e);
    endtask

    task idle(input int n);
        repeat (n) begin
            @(posedge clock);
            wr_stb <= 0; rd_stb <= 0;
        end
    endtask

    // A plain reset keeps only the range bit and the reset pin bit.
    task rst_pulse;
        @(posedge clock);
        sys_rst <= 1; wr_stb <= 0; rd_stb <= 0;
        @(posedge clock);
        sys_rst <= 0;
        m1 = m1 & 8'h08;
        m2 = m2 & 8'h01;
    endtask

    task check_opts(input logic ux);
        chk("wd_period", m1[7] ? `WOCR_WD_SHORT : `WOCR_WD_LONG,
            wd_period);
        if (in_halt)
            chk("wake_period",
                m1[7] ? `WOCR_WAKE_SHORT : `WOCR_WAKE_LONG, wake_period);
        chk("rec_delay",
            (m1[2] && !ux) ? `WOCR_REC_SHORT : `WOCR_REC_LONG, rec_delay);
        chk("uv_powered", !m1[4], uv_powered);
        chk("uv_in_halt", !m1[4] && m1[6], uv_in_halt);
        chk("uv_rst_out", uv_reset_req && !m1[5], uv_rst_out);
        chk("uv_range_hi", m1[3], uv_range_hi);
        chk("halt_allowed", m1[1], halt_allowed);
        chk("wd_enable", !m1[0], wd_enable);
        chk("pull_connect", !m2[7], pull_connect);
        chk("int_pin_on", m2[6], int_pin_on);
        chk("osc_src", m2[4:3], osc_src);
        chk("rst_pin_on", m2[0], rst_pin_on);
    endtask

    initial begin
        repeat (12) @(posedge clock);
        por_in <= 0; sys_rst <= 0;
        idle(4);
        for (int i = 0; i < 8; i++) begin
            rst_pulse;
            rd(8'h1f, m1); rd(8'h1e, m2);
            v1 = $random(seed);
            v2 = $random(seed);
            v2[4:3] = i[1:0];
            wr(8'h1f, v1); wr(8'h1e, v2);
            m1 = v1;
            m2 = v2;
            wr(8'h1f, ~v1); wr(8'h1e, ~v2);
            rd(8'h1f, m1); rd(8'h1e, m2);
            rd(8'h1d, 8'h00); rd(8'h20, 8'h00);
            uv_reset_req <= i[0]; halt_exit_by_uv <= i[1]; in_halt <= 1;
            idle(6);
            check_opts(i[1]);
            in_halt <= 0; uv_reset_req <= 0;
        end
        // Power-on clears even the bits that plain reset keeps.
        @(posedge clock);
        por_in <= 1;
        idle(4);
        por_in <= 0;
        idle(4);
        m1 = 8'h00;
        m2 = 8'h00;
        rd(8'h1f, m1); rd(8'h1e, m2);
        idle(4);
        check_opts(halt_exit_by_uv);
        final_report;
    end
endmodule
